// ===== hw/rioca_regs.svh
// Register offsets, field positions and reset values of the channel allocation block.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit offset field.
`ifndef RIOCA_REGS_SVH
`define RIOCA_REGS_SVH

`define RIOCA_OFF_CTRL      8'h00
`define RIOCA_OFF_STATUS    8'h04
`define RIOCA_OFF_FAULT     8'h08
`define RIOCA_OFF_IRQ_STAT  8'h0C
`define RIOCA_OFF_IRQ_MASK  8'h10
`define RIOCA_OFF_OUT_IMG   8'h14
`define RIOCA_OFF_IN_IMG    8'h18

`define RIOCA_CTRL_ACK      0
`define RIOCA_CTRL_REINIT   1

`define RIOCA_DIP_MODE      0
`define RIOCA_DIP_ADDR_LO   1
`define RIOCA_DIP_ADDR_HI   6
`define RIOCA_DIP_RESTART   7

`define RIOCA_ST_INIT_DONE  0
`define RIOCA_ST_MODE       1
`define RIOCA_ST_RESTART    2
`define RIOCA_ST_ADDR_LO    8
`define RIOCA_ST_ADDR_HI    13

`define RIOCA_FLT_LIVE_LO   16

`define RIOCA_IRQ_FAULT     0
`define RIOCA_IRQ_CLEARED   1
`define RIOCA_IRQ_FBWR      2
`define RIOCA_IRQ_W         3
`define RIOCA_IRQ_MASK_RST  3'h0

`define RIOCA_IMG_RST       16'h0000
`define RIOCA_ADDR_RST      6'h00
`define RIOCA_ADDR_STEP     6'h01

`endif

// ===== hw/rioca_pkg.sv
// Types shared by the channel allocation block.
// Assumes rioca_regs.svh supplies all numeric constants.
package rioca_pkg;
  typedef enum logic [1:0] {
    RIOCA_ST_RESET = 2'b00,
    RIOCA_ST_INIT  = 2'b01,
    RIOCA_ST_RUN   = 2'b10
  } rioca_state_t;

  typedef enum logic {
    RIOCA_MODE_SPLIT  = 1'b0,
    RIOCA_MODE_SINGLE = 1'b1
  } rioca_mode_t;

  typedef enum logic [1:0] {
    RIOCA_SEL_NONE = 2'b00,
    RIOCA_SEL_PRIM = 2'b01,
    RIOCA_SEL_SEC  = 2'b10
  } rioca_sel_t;
endpackage : rioca_pkg

// ===== hw/rioca_fault.sv
// Per-output overload latches and output shut-off for the 16 output channels.
// Assumes fault inputs are synchronous and high while a channel is overloaded.
`timescale 1ns/1ps
`default_nettype none
`include "rioca_regs.svh"
module rioca_fault (
  input  wire logic        i_clk,      // System clock
  input  wire logic        i_rst,      // Synchronous reset, high
  input  wire logic [15:0] i_fault,    // Live overload per output
  input  wire logic        i_ack,      // Acknowledge pulse, any source
  input  wire logic        i_hold,     // Live restart-select switch
  output logic      [15:0] o_latch,    // Latched error per output
  output logic      [15:0] o_off,      // Output forced off
  output logic             o_new,      // Pulse: a fault newly latched
  output logic             o_cleared   // Pulse: a latch was cleared
);
  logic [15:0] next_latch;

  // A fault still present blocks its own clear, so set always wins
  always_comb begin
    next_latch = o_latch | i_fault;
    if (i_ack) begin
      next_latch = next_latch & ~(o_latch & ~i_fault);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_latch   <= `RIOCA_IMG_RST;
      o_new     <= 1'b0;
      o_cleared <= 1'b0;
    end else begin
      o_latch   <= next_latch;
      o_new     <= |(i_fault & ~o_latch);
      o_cleared <= |(o_latch & ~next_latch);
    end
  end

  // Auto restart drops the latch from the gate; ack restart keeps it
  assign o_off = i_fault | (o_latch & {16{i_hold}});

  fault_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_fault != 16'h0000 |-> (o_off & i_fault) == i_fault)
    else $error("faulted output not switched off");
  auto_on_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_hold |-> o_off == i_fault)
    else $error("auto restart kept a cleared output off");
  ack_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_hold && !i_ack ##1 i_hold |-> (o_off & $past(o_latch)) == $past(o_latch))
    else $error("latched output restarted without acknowledge");
  clr_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 ((o_latch ^ $past(o_latch)) & $past(o_latch)) != 16'h0000 |-> $past(i_ack)
    && (($past(o_latch) & ~o_latch & $past(i_fault)) == 16'h0000))
    else $error("error latch cleared without acknowledge or with fault");
endmodule : rioca_fault
`default_nettype wire

// ===== hw/rioca_irq.sv
// Sticky interrupt status with mask; a status read clears it.
// Assumes event inputs are single-cycle pulses from the main block.
`timescale 1ns/1ps
`default_nettype none
`include "rioca_regs.svh"
module rioca_irq (
  input  wire logic [2:0] i_evt,       // Event pulses
  input  wire logic       i_clk,       // System clock
  input  wire logic       i_rst,       // Synchronous reset, high
  input  wire logic       i_rd_clr,    // Status read captured, first access cycle
  input  wire logic       i_mask_we,   // Mask write committed
  input  wire logic [2:0] i_mask_wd,   // Mask write data
  output logic      [2:0] o_stat,      // Sticky status
  output logic      [2:0] o_mask,      // Mask
  output logic            o_irq        // Level interrupt
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_stat <= `RIOCA_IRQ_MASK_RST;
    end else begin
      // An event in the clearing cycle survives
      o_stat <= (o_stat & ~{`RIOCA_IRQ_W{i_rd_clr}}) | i_evt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mask <= `RIOCA_IRQ_MASK_RST;
    end else if (i_mask_we) begin
      o_mask <= i_mask_wd;
    end
  end

  assign o_irq = |(o_stat & o_mask);

  evt_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_evt != 3'h0 |=> (o_stat & $past(i_evt)) == $past(i_evt))
    else $error("interrupt event lost");
endmodule : rioca_irq
`default_nettype wire

// ===== hw/rioca_top.sv
// Channel allocation, fieldbus image mapping and output fault restart of a 32-channel remote I/O unit.
// Assumes synchronous pins, a one-cycle fieldbus request strobe and an APB master on i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "rioca_regs.svh"

// Operation
// - Switch one on: 16 inputs, 16 outputs; combined channels are outputs only.
// - Switch one on: answer one address, channels 00 to 15 there.
// - Switch one off: 16 inputs, 8 outputs, combined channels individually usable.
// - Switch one off: two addresses; combined input states on next address 00-07.
// - Second address: outputs and inputs 08-15 are ignored.
// - Module address comes from switches two to seven.
// - Overloaded or shorted outputs switch off while the fault lasts.
// - Restart switch off: outputs come back by themselves once clear.
// - Restart switch on: outputs stay off until acknowledged by button, program, serial.
// - Switches are read once at initialization; changes wait for reinitialization.
// - Restart switch alone is followed continuously.
// - A driven combined channel reads back its actual pin state.
// - Error latches clear only when fault gone, none new, and acknowledged; here a new fault on another output does not block the clear.
module rioca_top (
  input  wire logic                   i_clk,        // 200 MHz clock
  input  wire logic                   i_rst,        // Synchronous reset, high
  input  wire logic                   i_psel,       // APB select
  input  wire logic                   i_penable,    // APB enable
  input  wire logic                   i_pwrite,     // APB direction
  input  wire logic [7:0]             i_paddr,      // APB byte address
  input  wire logic [31:0]            i_pwdata,     // APB write data
  output logic      [31:0]            o_prdata,     // APB read data
  output logic                        o_pready,     // APB ready
  output logic                        o_pslverr,    // APB error on unmapped address
  output logic                        o_irq,        // Interrupt level
  input  wire logic [7:0]             i_dip,        // Switches 1..8 on bits 0..7
  input  wire logic [15:0]            i_in_fixed,   // Fixed input pins
  input  wire logic [7:0]             i_comb_pin,   // Actual level of combined pins
  input  wire logic [15:0]            i_fault,      // Overload per output, combined on 15:8
  input  wire logic                   i_btn_ack,    // Test button long-press pulse
  input  wire logic                   i_fb_req,     // Fieldbus request strobe
  input  wire logic                   i_fb_we,      // Fieldbus request is output write
  input  wire logic [5:0]             i_fb_addr,    // Fieldbus module address
  input  wire logic [15:0]            i_fb_wdata,   // Fieldbus output image
  input  wire logic                   i_fb_ack_cmd, // Acknowledge connection element command
  output logic                        o_fb_ack,     // Fieldbus answer pulse
  output logic                        o_fb_hit,     // Answer addressed to this module
  output logic      [15:0]            o_fb_rdata,   // Fieldbus input image
  output logic      [7:0]             o_out_fixed,  // Fixed output drive
  output logic      [7:0]             o_out_comb,   // Combined channel drive
  output rioca_pkg::rioca_state_t     o_state,      // Init state
  output rioca_pkg::rioca_mode_t      o_mode        // Sampled allocation mode
);
  import rioca_pkg::*;

  rioca_state_t next_state;
  logic [5:0]   cfg_addr;
  logic [15:0]  out_img;
  logic [15:0]  flt_latch;
  logic [15:0]  flt_off;
  logic         flt_new;
  logic         flt_cleared;
  logic [2:0]   irq_stat;
  logic [2:0]   irq_mask;
  logic         rsp_rdy;
  logic         apb_access;
  logic         apb_commit;
  logic         apb_wr;
  logic         ack_any;
  logic         reinit;
  logic         fb_wr_evt;
  rioca_sel_t   fb_sel;

  function automatic rioca_sel_t sel_of(input logic [5:0] addr, input logic [5:0] base,
                                        input rioca_mode_t mode);
    rioca_sel_t s;
    s = RIOCA_SEL_NONE;
    if (addr == base) begin
      s = RIOCA_SEL_PRIM;
    end else if (mode == RIOCA_MODE_SPLIT && addr == 6'(base + `RIOCA_ADDR_STEP)) begin
      s = RIOCA_SEL_SEC;
    end
    return s;
  endfunction : sel_of

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `RIOCA_OFF_CTRL) || (addr == `RIOCA_OFF_STATUS) ||
                (addr == `RIOCA_OFF_FAULT) || (addr == `RIOCA_OFF_IRQ_STAT) ||
                (addr == `RIOCA_OFF_IRQ_MASK) || (addr == `RIOCA_OFF_OUT_IMG) ||
                (addr == `RIOCA_OFF_IN_IMG);
  endfunction : is_mapped

  // Init sequencing: switches are caught in the single INIT cycle only
  always_comb begin
    next_state = o_state;
    case (o_state)
      RIOCA_ST_RESET: next_state = RIOCA_ST_INIT;
      RIOCA_ST_INIT:  next_state = RIOCA_ST_RUN;
      RIOCA_ST_RUN:   next_state = reinit ? RIOCA_ST_INIT : RIOCA_ST_RUN;
      default:        next_state = RIOCA_ST_RESET;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_state <= RIOCA_ST_RESET;
    end else begin
      o_state <= next_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mode   <= RIOCA_MODE_SPLIT;
      cfg_addr <= `RIOCA_ADDR_RST;
    end else if (o_state == RIOCA_ST_INIT) begin
      o_mode   <= rioca_mode_t'(i_dip[`RIOCA_DIP_MODE]);
      cfg_addr <= i_dip[`RIOCA_DIP_ADDR_HI:`RIOCA_DIP_ADDR_LO];
    end
  end

  // APB: one wait cycle so read data comes from a flop
  assign apb_access = i_psel && i_penable;
  assign apb_commit = apb_access && rsp_rdy;
  assign apb_wr     = apb_commit && i_pwrite;
  assign o_pready   = apb_commit;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rsp_rdy <= 1'b0;
    end else begin
      rsp_rdy <= apb_access && !rsp_rdy;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (apb_access && !rsp_rdy) begin
      o_pslverr <= !is_mapped(i_paddr);
      o_prdata  <= 32'h0000_0000;
      if (!i_pwrite) begin
        case (i_paddr)
          `RIOCA_OFF_STATUS: begin
            o_prdata[`RIOCA_ST_INIT_DONE] <= (o_state == RIOCA_ST_RUN);
            o_prdata[`RIOCA_ST_MODE]      <= o_mode;
            o_prdata[`RIOCA_ST_RESTART]   <= i_dip[`RIOCA_DIP_RESTART];
            o_prdata[`RIOCA_ST_ADDR_HI:`RIOCA_ST_ADDR_LO] <= cfg_addr;
          end
          `RIOCA_OFF_FAULT:    o_prdata <= {i_fault, flt_latch};
          `RIOCA_OFF_IRQ_STAT: o_prdata[`RIOCA_IRQ_W-1:0] <= irq_stat;
          `RIOCA_OFF_IRQ_MASK: o_prdata[`RIOCA_IRQ_W-1:0] <= irq_mask;
          `RIOCA_OFF_OUT_IMG:  o_prdata[15:0] <= out_img;
          `RIOCA_OFF_IN_IMG:   o_prdata[23:0] <= {i_comb_pin, i_in_fixed};
          default:             o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reinit  = apb_wr && (i_paddr == `RIOCA_OFF_CTRL) && i_pwdata[`RIOCA_CTRL_REINIT];
  assign ack_any = i_btn_ack || i_fb_ack_cmd ||
                   (apb_wr && (i_paddr == `RIOCA_OFF_CTRL) && i_pwdata[`RIOCA_CTRL_ACK]);

  // Fieldbus image access, answered one cycle after the strobe
  assign fb_sel    = sel_of(i_fb_addr, cfg_addr, o_mode);
  assign fb_wr_evt = i_fb_req && i_fb_we && fb_sel == RIOCA_SEL_PRIM && o_state == RIOCA_ST_RUN;

  always_ff @(posedge i_clk) begin
    if (i_rst || o_state == RIOCA_ST_INIT) begin
      out_img <= `RIOCA_IMG_RST;
    end else if (fb_wr_evt) begin
      // Combined outputs take bits 15:8 in both modes; second address writes dropped
      out_img <= i_fb_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fb_ack   <= 1'b0;
      o_fb_hit   <= 1'b0;
      o_fb_rdata <= `RIOCA_IMG_RST;
    end else begin
      o_fb_ack   <= i_fb_req;
      o_fb_hit   <= 1'b0;
      o_fb_rdata <= `RIOCA_IMG_RST;
      if (i_fb_req && o_state == RIOCA_ST_RUN) begin
        case (fb_sel)
          RIOCA_SEL_PRIM: begin
            o_fb_hit   <= 1'b1;
            o_fb_rdata <= i_fb_we ? `RIOCA_IMG_RST : i_in_fixed;
          end
          RIOCA_SEL_SEC: begin
            // Upper half stays zero: those channels belong to other modules
            o_fb_hit   <= !i_fb_we;
            o_fb_rdata <= i_fb_we ? `RIOCA_IMG_RST : {8'h00, i_comb_pin};
          end
          default: begin
            o_fb_hit   <= 1'b0;
            o_fb_rdata <= `RIOCA_IMG_RST;
          end
        endcase
      end
    end
  end

  rioca_fault u_fault (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_fault   (i_fault),
    .i_ack     (ack_any),
    .i_hold    (i_dip[`RIOCA_DIP_RESTART]),
    .o_latch   (flt_latch),
    .o_off     (flt_off),
    .o_new     (flt_new),
    .o_cleared (flt_cleared)
  );

  rioca_irq u_irq (
    .i_evt     ({fb_wr_evt, flt_cleared, flt_new}),
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    // Clear at the capture edge: an event in the wait cycle would otherwise vanish unread
    .i_rd_clr  (apb_access && !rsp_rdy && !i_pwrite && i_paddr == `RIOCA_OFF_IRQ_STAT),
    .i_mask_we (apb_wr && i_paddr == `RIOCA_OFF_IRQ_MASK),
    .i_mask_wd (i_pwdata[`RIOCA_IRQ_W-1:0]),
    .o_stat    (irq_stat),
    .o_mask    (irq_mask),
    .o_irq     (o_irq)
  );

  // Drive stays low outside RUN so a half-configured unit switches nothing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_out_fixed <= 8'h00;
      o_out_comb  <= 8'h00;
    end else if (o_state != RIOCA_ST_RUN) begin
      o_out_fixed <= 8'h00;
      o_out_comb  <= 8'h00;
    end else begin
      o_out_fixed <= out_img[7:0] & ~flt_off[7:0];
      o_out_comb  <= out_img[15:8] & ~flt_off[15:8];
    end
  end

  // Fieldbus access patterns shared by the answer checks below
  sequence fb_read_prim_s;
    i_fb_req && !i_fb_we && o_state == RIOCA_ST_RUN && i_fb_addr == cfg_addr;
  endsequence

  sequence fb_read_sec_s;
    i_fb_req && !i_fb_we && o_state == RIOCA_ST_RUN && o_mode == RIOCA_MODE_SPLIT &&
      i_fb_addr == 6'(cfg_addr + `RIOCA_ADDR_STEP);
  endsequence

  sequence fb_write_sec_s;
    i_fb_req && i_fb_we && o_state == RIOCA_ST_RUN && o_mode == RIOCA_MODE_SPLIT &&
      i_fb_addr == 6'(cfg_addr + `RIOCA_ADDR_STEP);
  endsequence

  // Switch capture: only the restart switch may act between initializations
  cfg_frozen_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state == RIOCA_ST_RUN && $past(o_state) == RIOCA_ST_RUN |-> $stable(cfg_addr) && $stable(o_mode))
    else $error("configuration changed outside initialization");

  addr_source_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state == RIOCA_ST_INIT |=> cfg_addr == $past(i_dip[`RIOCA_DIP_ADDR_HI:`RIOCA_DIP_ADDR_LO]))
    else $error("module address not taken from switches two to seven");

  // Re-initialization starts from an empty output image
  img_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state == RIOCA_ST_INIT |=> out_img == `RIOCA_IMG_RST)
    else $error("output image kept across initialization");

  // Address decoding and image return on the fieldbus
  single_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_fb_req && o_mode == RIOCA_MODE_SINGLE && i_fb_addr != cfg_addr |=> o_fb_ack && !o_fb_hit)
    else $error("single-address unit answered a foreign address");

  hit_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_fb_req && o_state != RIOCA_ST_RUN |=> !o_fb_hit && o_fb_rdata == `RIOCA_IMG_RST)
    else $error("request answered before initialization ended");

  prim_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fb_read_prim_s |=> o_fb_hit && o_fb_rdata == $past(i_in_fixed))
    else $error("primary address read did not return fixed inputs");

  sec_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fb_read_sec_s |=> o_fb_hit && o_fb_rdata == {8'h00, $past(i_comb_pin)})
    else $error("second address read did not return combined pin state");

  sec_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fb_write_sec_s |=> !o_fb_hit && $stable(out_img))
    else $error("second address write was not ignored");

  wr_event_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fb_wr_evt |=> irq_stat[`RIOCA_IRQ_FBWR])
    else $error("output write event not recorded");

  // Output drive: image gated by the fault logic, nothing outside RUN
  prim_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fb_wr_evt ##1 o_state == RIOCA_ST_RUN ##1 o_state == RIOCA_ST_RUN
      |-> o_out_comb == ($past(i_fb_wdata[15:8], 2) & ~$past(flt_off[15:8])))
    else $error("combined outputs do not follow the primary image");

  idle_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state != RIOCA_ST_RUN |=> o_out_fixed == 8'h00 && o_out_comb == 8'h00)
    else $error("outputs driven outside normal operation");

  out_fault_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_fault != 16'h0000 |=> ({o_out_comb, o_out_fixed} & $past(i_fault)) == 16'h0000)
    else $error("overloaded output still driven");

  // With the restart switch off the whole image comes straight back
  restart_live_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state == RIOCA_ST_RUN && !i_dip[`RIOCA_DIP_RESTART] && i_fault == 16'h0000 ##1
      o_state == RIOCA_ST_RUN |-> o_out_fixed == $past(out_img[7:0]))
    else $error("restart switch not followed during operation");

  auto_comb_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state == RIOCA_ST_RUN && !i_dip[`RIOCA_DIP_RESTART] && i_fault == 16'h0000
      |=> o_out_comb == $past(out_img[15:8]))
    else $error("combined outputs not restarted automatically");

  // With the switch on, a latched channel stays dark until acknowledged
  ack_restart_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_dip[`RIOCA_DIP_RESTART] && flt_latch != 16'h0000
      |=> ({o_out_comb, o_out_fixed} & $past(flt_latch)) == 16'h0000)
    else $error("latched channel driven before acknowledge");

  clr_acked_a: assert property (@(posedge i_clk) disable iff (i_rst)
    flt_cleared |-> $past(ack_any))
    else $error("error clear reported without acknowledge");

  // Register bus: one fixed wait state, error only on unmapped offsets
  apb_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_psel && !i_penable ##1 apb_access |-> !o_pready ##1 o_pready)
    else $error("APB answer not in second access cycle");

  pslv_err_a: assert property (@(posedge i_clk) disable iff (i_rst)
    apb_commit |-> o_pslverr == !is_mapped(i_paddr))
    else $error("slave error does not match address decode");
endmodule : rioca_top
`default_nettype wire

// ===== sim/rioca_fb_master.sv
// Fieldbus master model: one-cycle request strobes, answer taken the cycle after.
// Assumes the unit answers every request on the next cycle.
`timescale 1ns/1ps
`default_nettype none
module rioca_fb_master (
  input  wire logic        i_clk,     // Clock
  input  wire logic        i_ack,     // Answer pulse
  input  wire logic        i_hit,     // Answer is ours
  input  wire logic [15:0] i_rdata,   // Input image
  output logic             o_req,     // Request strobe
  output logic             o_we,      // Write request
  output logic      [5:0]  o_addr,    // Module address
  output logic      [15:0] o_wdata,   // Output image
  output logic             o_ack_cmd  // Acknowledge command
);
  logic [7:0] comb_in;  // Combined channels used as inputs
  initial begin
    comb_in = 8'h00;
    o_req = 1'b0;
    o_we = 1'b0;
    o_addr = 6'h00;
    o_wdata = 16'h0000;
    o_ack_cmd = 1'b0;
  end
  // Lines flip between requests so a stale value never passes for a fresh one
  task automatic xfer(input logic we, input logic [5:0] a, input logic [15:0] d,
                      output logic ack, output logic hit, output logic [15:0] rd);
    logic [15:0] wd;
    wd = we ? (d & ~{comb_in, 8'h00}) : d;
    @(posedge i_clk);
    o_req <= 1'b1;
    o_we <= we;
    o_addr <= a;
    o_wdata <= wd;
    @(posedge i_clk);
    o_req <= 1'b0;
    o_we <= ~we;
    o_addr <= ~a;
    o_wdata <= ~wd;
    @(posedge i_clk);
    ack = i_ack;
    hit = i_hit;
    rd = i_rdata;
  endtask : xfer
  task automatic ack_cmd();
    @(posedge i_clk);
    o_ack_cmd <= 1'b1;
    @(posedge i_clk);
    o_ack_cmd <= 1'b0;
  endtask : ack_cmd
endmodule : rioca_fb_master
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the channel allocation block.
// Assumes rioca_fb_master stands in for the fieldbus master.
`timescale 1ns/1ps
`default_nettype none
`include "rioca_regs.svh"
module tb_top;
  import rioca_pkg::*;
  logic         i_clk, i_rst, i_psel, i_penable, i_pwrite, i_btn_ack;
  logic         i_fb_req, i_fb_we, i_fb_ack_cmd, o_pready, o_pslverr, o_irq;
  logic         o_fb_ack, o_fb_hit, er, fa, fh;
  logic [7:0]   i_paddr, i_dip, i_comb_pin, o_out_fixed, o_out_comb;
  logic [31:0]  i_pwdata, o_prdata, rd;
  logic [15:0]  i_in_fixed, i_fault, i_fb_wdata, o_fb_rdata, frd;
  logic [5:0]   i_fb_addr;
  rioca_state_t o_state;
  rioca_mode_t  o_mode;
  int           fails, comparisons;

  rioca_top i_dut (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq, .i_dip, .i_in_fixed,
    .i_comb_pin, .i_fault, .i_btn_ack, .i_fb_req, .i_fb_we, .i_fb_addr,
    .i_fb_wdata, .i_fb_ack_cmd, .o_fb_ack, .o_fb_hit, .o_fb_rdata,
    .o_out_fixed, .o_out_comb, .o_state, .o_mode);
  rioca_fb_master i_fbm (.i_clk(i_clk), .i_ack(o_fb_ack), .i_hit(o_fb_hit),
    .i_rdata(o_fb_rdata), .o_req(i_fb_req), .o_we(i_fb_we), .o_addr(i_fb_addr),
    .o_wdata(i_fb_wdata), .o_ack_cmd(i_fb_ack_cmd));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      wrap_up();
    end
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rchk

  task automatic fb(input logic we, input logic [5:0] a, input logic [15:0] d,
                    input logic hit, input logic [15:0] exp);
    i_fbm.xfer(we, a, d, fa, fh, frd);
    chk("fb_ack", 32'h1, {31'h0, fa});
    chk("fb_hit", {31'h0, hit}, {31'h0, fh});
    chk("fb_rdata", {16'h0, exp}, {16'h0, frd});
  endtask : fb

  task automatic outs(input logic [15:0] exp);
    repeat (3) @(posedge i_clk);
    chk("outputs", {16'h0, exp}, {16'h0, o_out_comb, o_out_fixed});
  endtask : outs

  task automatic pulse_btn();
    @(posedge i_clk);
    i_btn_ack <= 1'b1;
    @(posedge i_clk);
    i_btn_ack <= 1'b0;
  endtask : pulse_btn

  task automatic s_single();
    rchk("status", `RIOCA_OFF_STATUS, 32'h0000_0A03);
    chk("state", {30'h0, RIOCA_ST_RUN}, {30'h0, o_state});
    rchk("irq_mask", `RIOCA_OFF_IRQ_MASK, 32'h0);
    chk("slverr", 32'h0, {31'h0, er});
    rchk("unmapped", 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("mode", 32'h1, {31'h0, o_mode});
    fb(1'b0, 6'd10, 16'h0, 1'b1, 16'h3C5A);
    fb(1'b1, 6'd10, 16'hA55A, 1'b1, 16'h0);
    outs(16'hA55A);
    fb(1'b0, 6'd11, 16'h0, 1'b0, 16'h0);
    fb(1'b1, 6'd11, 16'hFFFF, 1'b0, 16'h0);
  endtask : s_single

  task automatic s_reinit();
    i_dip <= 8'h18;
    rchk("status", `RIOCA_OFF_STATUS, 32'h0000_0A03);
    fb(1'b0, 6'd10, 16'h0, 1'b1, 16'h3C5A);
    apb(1'b1, `RIOCA_OFF_CTRL, 32'h0000_0002);
    rchk("status", `RIOCA_OFF_STATUS, 32'h0000_0C01);
    chk("mode", 32'h0, {31'h0, o_mode});
  endtask : s_reinit

  task automatic s_split();
    i_fbm.comb_in = 8'h0F;
    i_comb_pin <= 8'hF6;
    fb(1'b1, 6'd12, 16'hFF33, 1'b1, 16'h0);
    outs(16'hF033);
    fb(1'b0, 6'd13, 16'h0, 1'b1, 16'h00F6);
    fb(1'b1, 6'd13, 16'hFFFF, 1'b0, 16'h0);
    outs(16'hF033);
    rchk("out_img", `RIOCA_OFF_OUT_IMG, 32'h0000_F033);
    rchk("in_img", `RIOCA_OFF_IN_IMG, 32'h00F6_3C5A);
    fb(1'b0, 6'd12, 16'h0, 1'b1, 16'h3C5A);
  endtask : s_split

  task automatic s_auto();
    apb(1'b1, `RIOCA_OFF_IRQ_MASK, 32'h0000_0007);
    rchk("irq_mask", `RIOCA_OFF_IRQ_MASK, 32'h7);
    rchk("irq_stat", `RIOCA_OFF_IRQ_STAT, 32'h4);
    i_fault <= 16'h0001;
    outs(16'hF032);
    chk("irq", 32'h1, {31'h0, o_irq});
    i_fault <= 16'h0000;
    outs(16'hF033);
    rchk("fault", `RIOCA_OFF_FAULT, 32'h0000_0001);
    i_fbm.ack_cmd();
    rchk("fault", `RIOCA_OFF_FAULT, 32'h0);
    rchk("irq_stat", `RIOCA_OFF_IRQ_STAT, 32'h3);
    @(posedge i_clk);
    chk("irq", 32'h0, {31'h0, o_irq});
  endtask : s_auto

  task automatic s_ack();
    i_dip <= 8'h98;
    rchk("status", `RIOCA_OFF_STATUS, 32'h0000_0C05);
    i_fault <= 16'h1000;
    outs(16'hE033);
    i_fault <= 16'h0000;
    outs(16'hE033);
    i_fault <= 16'h1000;
    apb(1'b1, `RIOCA_OFF_CTRL, 32'h0000_0001);
    rchk("fault", `RIOCA_OFF_FAULT, 32'h1000_1000);
    i_fault <= 16'h0000;
    outs(16'hE033);
    apb(1'b1, `RIOCA_OFF_IRQ_MASK, 32'h0);
    pulse_btn();
    outs(16'hF033);
    chk("irq", 32'h0, {31'h0, o_irq});
    rchk("irq_stat", `RIOCA_OFF_IRQ_STAT, 32'h3);
  endtask : s_ack

  initial begin
    fails = 0;
    comparisons = 0;
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    i_btn_ack = 1'b0;
    i_dip = 8'h15;
    i_in_fixed = 16'h3C5A;
    i_comb_pin = 8'h81;
    i_fault = 16'h0000;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    s_single();
    s_reinit();
    s_split();
    s_auto();
    s_ack();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
